// *** logic/dio_pkg.sv ***
// Purpose: Shared constants for the mixed digital I/O unit with diagnostics
// Assumes: Single 20 MHz system clock
// Notes:   Record layout, codes, reset values and timing counts live here
package dio_pkg;

	// Channel widths
	localparam int CHANNELS = 8;

	// Process image offsets (input and output images share offset 0)
	localparam logic [7:0] IMAGE_OFFSET = 8'h00;

	// Diagnostic record number and byte layout
	localparam logic [7:0] DIAG_RECORD_NUM   = 8'h01;
	localparam int         REC_BYTES         = 20;
	localparam int         REC_AW            = 5;
	localparam logic [4:0] REC_ERROR_FLAGS   = 5'h00;
	localparam logic [4:0] REC_MODULE_CLASS  = 5'h01;
	localparam logic [4:0] REC_RESERVED_C    = 5'h02;
	localparam logic [4:0] REC_RESERVED_D    = 5'h03;
	localparam logic [4:0] REC_CHANNEL_KIND  = 5'h04;
	localparam logic [4:0] REC_BITS_PER_CH   = 5'h05;
	localparam logic [4:0] REC_CHANNEL_COUNT = 5'h06;
	localparam logic [4:0] REC_CH_SUMMARY    = 5'h07;
	localparam logic [4:0] REC_PER_CH_FIRST  = 5'h08;
	localparam logic [4:0] REC_TIMESTAMP_B0  = 5'h10;
	localparam logic [4:0] REC_LAST          = 5'h13;

	// Error flag bit positions in the first record byte
	localparam int FLAG_MODULE_FAIL = 0;
	localparam int FLAG_INTERNAL    = 1;
	localparam int FLAG_EXTERNAL    = 2;
	localparam int FLAG_OVERLOAD    = 4;
	localparam int FLAG_PARAM       = 7;

	// Fixed record contents and reset values
	localparam logic [7:0] ERROR_FLAGS_RESET  = 8'h00;
	localparam logic [7:0] MODULE_CLASS_INFO  = 8'h0F;
	localparam logic [7:0] CHANNEL_KIND_CODE  = 8'h72;
	localparam logic [7:0] DIAG_BITS_PER_CH   = 8'h00;
	localparam logic [7:0] CHANNEL_COUNT_CODE = 8'h00;
	localparam logic [7:0] RESERVED_BYTE      = 8'h00;
	localparam logic [7:0] IMAGE_RESET        = 8'h00;

	// Timing: clock rate, microsecond tick, 1 Hz blink half period
	localparam int CLK_HZ        = 20_000_000;
	localparam int TICK_US       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_CYCLES  = BLINK_HALF_MS * (CLK_HZ / 1000);

	// Record refresh sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_FILL = 2'b01
	} seq_state_t;

endpackage

// *** logic/diag_record_mem.sv ***
// Purpose: Byte store holding the diagnostic record snapshot
// Assumes: One write port, one registered read port
// Notes:   Read data come out of a register; zero_rd forces a zero answer
`timescale 1ns/1ns
`default_nettype none
module diag_record_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 20,
	parameter int AW    = 5
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic             rd_en,
	input  wire logic             zero_rd,
	input  wire logic [AW-1:0]    rd_addr,
	output var  logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] store [DEPTH];
	wire              rd_hit = rd_en && !zero_rd && (32'(rd_addr) < DEPTH);

	// Storage array, no reset needed since the sequencer fills it
	always_ff @(posedge clk_sys) begin
		if (wr_en && (32'(wr_addr) < DEPTH)) begin
			store[wr_addr] <= wr_data;
		end
	end

	// Registered read; out-of-range or refused reads give zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_hit) begin
			rd_data <= store[rd_addr];
		end else if (rd_en) begin
			rd_data <= '0;
		end
	end

endmodule
`default_nettype wire

// *** logic/mixed_digital_io_diag.sv ***
// Purpose: Mixed 8-in/8-out digital unit with overload diagnostics and LEDs
// Assumes: Head station ports synchronous to clk_sys at 20 MHz
// Notes:   Diagnostic record is refreshed into a byte store on each event
//
// Functional notes
// - Input image byte bit n carries input channel n.
// - Head station writes output image byte; bit n drives output n.
// - With interrupt enabled, overload raises incoming interrupt; disabled raises none.
// - Red status light follows overload regardless of interrupt setting.
// - When the cause clears, a going interrupt follows automatically if an incoming one was sent.
// - Record number 01h returns the diagnostic record.
// - Flag byte: bit0 failure, 1 internal, 2 external, 4 overload, 7 parameter.
// - Module information byte reads 0Fh, digital module class.
// - Channel type byte reads 72h, digital output.
// - Bits-per-channel and channel-count bytes read 00h.
// - Record: eight fields, eight zero bytes, four timestamp bytes.
// - A diagnostic event captures the microsecond ticker into the timestamp.
// - Ticker starts at 0, counts microseconds, wraps after 32-bit maximum.
// - Green status lights steady on while bus and module are healthy.
// - Red status light steady on while the module reports an error other than a configuration error.
// - Configuration error flashes red status light at 1 Hz.
// - Backplane communication error flashes green status lights at 1 Hz.
// - Each channel's green light shows that channel's logic level.
`timescale 1ns/1ns
`default_nettype none
module mixed_digital_io_diag #(
	parameter int BLINK_HALF_CYCLES = dio_pkg::BLINK_CYCLES,
	parameter int CH                = dio_pkg::CHANNELS
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Field channels
	input  wire logic [CH-1:0] field_in,
	output var  logic [CH-1:0] field_out,
	input  wire logic [CH-1:0] out_overload,
	// Module condition inputs
	input  wire logic          diag_irq_enable,
	input  wire logic          module_failure,
	input  wire logic          internal_error,
	input  wire logic          external_error,
	input  wire logic          param_error,
	input  wire logic          bus_comm_error,
	// Process images
	output var  logic [7:0]    input_image_byte,
	input  wire logic          out_image_wr,
	input  wire logic [7:0]    out_image_data,
	output var  logic [7:0]    output_image_byte,
	// Record read port
	input  wire logic          rec_rd,
	input  wire logic [7:0]    rec_num,
	input  wire logic [4:0]    rec_idx,
	output var  logic          rec_valid,
	output var  logic          rec_refused,
	output var  logic [7:0]    rec_data,
	// Diagnostic interrupts
	output var  logic          diag_irq_incoming,
	output var  logic          diag_irq_going,
	// Status bar and channel lights
	output var  logic          led_status_green,
	output var  logic          led_status_red,
	output var  logic [CH-1:0] led_in,
	output var  logic [CH-1:0] led_out
);

	localparam int TW = $clog2(dio_pkg::TICK_CYCLES);
	localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST  = TW'(dio_pkg::TICK_CYCLES - 1);
	localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);

	// Builds one record byte from its position, the flags and the timestamp
	function automatic logic [7:0] record_byte(
		input logic [4:0]  idx,
		input logic [7:0]  flags,
		input logic [31:0] stamp
	);
		logic [7:0] b;
		b = dio_pkg::RESERVED_BYTE;
		case (idx)
			dio_pkg::REC_ERROR_FLAGS:   b = flags;
			dio_pkg::REC_MODULE_CLASS:  b = dio_pkg::MODULE_CLASS_INFO;
			dio_pkg::REC_CHANNEL_KIND:  b = dio_pkg::CHANNEL_KIND_CODE;
			dio_pkg::REC_BITS_PER_CH:   b = dio_pkg::DIAG_BITS_PER_CH;
			dio_pkg::REC_CHANNEL_COUNT: b = dio_pkg::CHANNEL_COUNT_CODE;
			default: begin
				if (idx >= dio_pkg::REC_TIMESTAMP_B0) begin
					b = stamp[8*(idx - dio_pkg::REC_TIMESTAMP_B0) +: 8];
				end
			end
		endcase
		return b;
	endfunction

	// Registers
	logic [TW-1:0]           prescale;
	logic [31:0]             ticker;
	logic [BW-1:0]           blink_cnt;
	logic                    blink;
	logic [7:0]              flags_prev;
	logic                    overload_prev;
	logic                    irq_armed;
	logic [7:0]              snap_flags;
	logic [31:0]             snap_stamp;
	logic [4:0]              fill_idx;
	dio_pkg::seq_state_t     seq;
	dio_pkg::seq_state_t     next_seq;

	// Condition decode
	wire       overload_any = |out_overload;
	wire [7:0] flags_now;
	assign flags_now[dio_pkg::FLAG_MODULE_FAIL] = module_failure;
	assign flags_now[dio_pkg::FLAG_INTERNAL]    = internal_error;
	assign flags_now[dio_pkg::FLAG_EXTERNAL]    = external_error;
	assign flags_now[3]                         = 1'b0;
	assign flags_now[dio_pkg::FLAG_OVERLOAD]    = overload_any;
	assign flags_now[6:5]                       = 2'b00;
	assign flags_now[dio_pkg::FLAG_PARAM]       = param_error;

	// Event and tick decode
	wire tick_us      = (prescale == TICK_LAST);
	wire blink_wrap   = (blink_cnt == BLINK_LAST);
	wire diag_event   = (flags_now != flags_prev);
	wire ovl_rise     = overload_any && !overload_prev;
	wire ovl_fall     = !overload_any && overload_prev;
	wire irq_raise    = diag_irq_enable && ovl_rise;
	wire irq_clear    = ovl_fall && irq_armed;
	wire module_ok    = (flags_now == dio_pkg::ERROR_FLAGS_RESET);
	wire fill_last    = (fill_idx == dio_pkg::REC_LAST);
	wire [7:0] fill_byte = record_byte(fill_idx, snap_flags, snap_stamp);

	// Record read decode
	wire rec_wrong    = (rec_num != dio_pkg::DIAG_RECORD_NUM);
	wire rec_too_far  = (rec_idx > dio_pkg::REC_LAST);
	wire rec_zero     = rec_wrong || rec_too_far;

	// LED decode
	wire next_red     = param_error ? blink : !module_ok;
	wire next_green   = bus_comm_error ? blink : module_ok;

	// Sequencer next state
	always_comb begin
		next_seq = seq;
		case (seq)
			dio_pkg::SEQ_IDLE: begin
				if (diag_event) begin
					next_seq = dio_pkg::SEQ_FILL;
				end
			end
			dio_pkg::SEQ_FILL: begin
				if (fill_last && !diag_event) begin
					next_seq = dio_pkg::SEQ_IDLE;
				end
			end
			default: next_seq = dio_pkg::SEQ_IDLE;
		endcase
	end

	// Microsecond prescaler, restarts at power-on
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prescale <= '0;
		end else if (tick_us) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + TW'(1);
		end
	end

	// Free-running microsecond ticker, wraps naturally at 32 bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ticker <= 32'h0000_0000;
		end else if (tick_us) begin
			ticker <= ticker + 32'h0000_0001;
		end
	end

	// Half-second toggle for the 1 Hz blink
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			blink_cnt <= '0;
			blink     <= 1'b0;
		end else if (blink_wrap) begin
			blink_cnt <= '0;
			blink     <= !blink;
		end else begin
			blink_cnt <= blink_cnt + BW'(1);
		end
	end

	// Input image samples the field inputs every cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			input_image_byte <= dio_pkg::IMAGE_RESET;
		end else begin
			input_image_byte <= field_in;
		end
	end

	// Output image and field drive change only on a head station write
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			output_image_byte <= dio_pkg::IMAGE_RESET;
			field_out         <= '0;
		end else if (out_image_wr) begin
			output_image_byte <= out_image_data;
			field_out         <= out_image_data;
		end
	end

	// Input channel lights follow the input levels
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			led_in <= '0;
		end else begin
			led_in <= field_in;
		end
	end

	// Output channel lights follow the driven levels
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			led_out <= '0;
		end else begin
			led_out <= field_out;
		end
	end

	// Red status light
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			led_status_red <= 1'b0;
		end else begin
			led_status_red <= next_red;
		end
	end

	// Green status lights
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			led_status_green <= 1'b0;
		end else begin
			led_status_green <= next_green;
		end
	end

	// Overload history for the edge detectors; resets to the idle level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			overload_prev <= 1'b0;
		end else begin
			overload_prev <= overload_any;
		end
	end

	// Incoming interrupt stays armed until its going partner is sent
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_armed <= 1'b0;
		end else if (irq_raise) begin
			irq_armed <= 1'b1;
		end else if (irq_clear) begin
			irq_armed <= 1'b0;
		end
	end

	// Incoming and going diagnostic interrupt pulses
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			diag_irq_incoming <= 1'b0;
			diag_irq_going    <= 1'b0;
		end else begin
			diag_irq_incoming <= irq_raise;
			diag_irq_going    <= irq_clear;
		end
	end

	// Previous flag byte, used to spot diagnostic events
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_prev <= dio_pkg::ERROR_FLAGS_RESET;
		end else begin
			flags_prev <= flags_now;
		end
	end

	// Snapshot of flags and ticker at each diagnostic event
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			snap_flags <= dio_pkg::ERROR_FLAGS_RESET;
			snap_stamp <= 32'h0000_0000;
		end else if (diag_event) begin
			snap_flags <= flags_now;
			snap_stamp <= ticker;
		end
	end

	// Sequencer state; reset starts with a full fill of the store
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			seq <= dio_pkg::SEQ_FILL;
		end else begin
			seq <= next_seq;
		end
	end

	// Fill index walks all record bytes; an event restarts it from byte 0
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fill_idx <= dio_pkg::REC_ERROR_FLAGS;
		end else if (diag_event) begin
			fill_idx <= dio_pkg::REC_ERROR_FLAGS;
		end else if (seq == dio_pkg::SEQ_FILL && !fill_last) begin
			fill_idx <= fill_idx + 5'h01;
		end
	end

	// Read handshake flags
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rec_valid   <= 1'b0;
			rec_refused <= 1'b0;
		end else begin
			rec_valid   <= rec_rd;
			rec_refused <= rec_rd && rec_zero;
		end
	end

	// Record byte store with registered read data
	diag_record_mem #(
		.WIDTH (8),
		.DEPTH (dio_pkg::REC_BYTES),
		.AW    (dio_pkg::REC_AW)
	) u_record (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wr_en   (seq == dio_pkg::SEQ_FILL),
		.wr_addr (fill_idx),
		.wr_data (fill_byte),
		.rd_en   (rec_rd),
		.zero_rd (rec_zero),
		.rd_addr (rec_idx),
		.rd_data (rec_data)
	);

endmodule
`default_nettype wire

// *** tb/mixed_digital_io_diag_assertions.sv ***
// Purpose: Port-level checks for the mixed digital I/O unit
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module mixed_digital_io_diag_assertions #(
	parameter int BLINK_HALF_CYCLES = 8,
	parameter int CH                = 8
) (
	// Clock, reset and stimulus side
	input wire logic          clk_sys,
	input wire logic          rst_n,
	input wire logic [CH-1:0] field_in,
	input wire logic [CH-1:0] out_overload,
	input wire logic          diag_irq_enable,
	input wire logic          module_failure,
	input wire logic          internal_error,
	input wire logic          external_error,
	input wire logic          param_error,
	input wire logic          bus_comm_error,
	input wire logic          out_image_wr,
	input wire logic [7:0]    out_image_data,
	input wire logic          rec_rd,
	input wire logic [7:0]    rec_num,
	input wire logic [4:0]    rec_idx,
	// Design answers
	input wire logic [7:0]    input_image_byte,
	input wire logic [7:0]    output_image_byte,
	input wire logic          rec_valid,
	input wire logic          rec_refused,
	input wire logic [7:0]    rec_data,
	input wire logic          diag_irq_incoming,
	input wire logic          diag_irq_going,
	input wire logic          led_status_green,
	input wire logic          led_status_red,
	input wire logic [CH-1:0] led_out
);
	// Overload summary
	wire logic ov_any = |out_overload;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Incoming pulse that still awaits its going pulse
	logic armed;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (diag_irq_incoming) begin
			armed <= 1'b1;
		end else if (diag_irq_going) begin
			armed <= 1'b0;
		end
	end
	// Overload edges
	sequence s_ov_on;
		$rose(ov_any);
	endsequence
	sequence s_ov_off;
		$fell(ov_any);
	endsequence
	chk_in_image: assert property ($past(rst_n) |-> input_image_byte == $past(field_in))
		else $error("input image does not follow the inputs");
	chk_out_image: assert property (out_image_wr |=> output_image_byte == $past(out_image_data))
		else $error("output image not taken");
	chk_led_out: assert property (led_out == $past(output_image_byte))
		else $error("output lights do not follow the image");
	chk_rec_valid: assert property ($past(rst_n) |-> rec_valid == $past(rec_rd))
		else $error("record answer missing or spurious");
	chk_rec_refuse: assert property (
		rec_rd |=> rec_refused == ($past(rec_num) != 8'h01 || $past(rec_idx) > 5'h13))
		else $error("record refusal wrong");
	chk_refused_zero: assert property (rec_valid && rec_refused |-> rec_data == 8'h00)
		else $error("refused read returned data");
	chk_irq_rise: assert property (s_ov_on ##0 diag_irq_enable |=> diag_irq_incoming)
		else $error("incoming interrupt missing");
	chk_irq_masked: assert property (s_ov_on ##0 !diag_irq_enable |=> !diag_irq_incoming)
		else $error("interrupt raised while disabled");
	chk_irq_going: assert property (s_ov_off ##0 (armed || diag_irq_incoming) |=> diag_irq_going)
		else $error("going interrupt missing");
	chk_going_unarmed: assert property (s_ov_off ##0 !(armed || diag_irq_incoming) |=> !diag_irq_going)
		else $error("going interrupt without incoming");
	chk_red_light: assert property (
		$past(rst_n) && !$past(param_error) |->
		led_status_red == $past(ov_any | module_failure | internal_error | external_error))
		else $error("red status light wrong");
	chk_green_light: assert property (
		$past(rst_n) && !$past(bus_comm_error) |-> led_status_green ==
		!$past(ov_any | module_failure | internal_error | external_error | param_error))
		else $error("green status light wrong");
endmodule
bind mixed_digital_io_diag mixed_digital_io_diag_assertions #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES), .CH(CH)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .field_in(field_in), .out_overload(out_overload),
	.diag_irq_enable(diag_irq_enable), .module_failure(module_failure), .internal_error(internal_error),
	.external_error(external_error), .param_error(param_error), .bus_comm_error(bus_comm_error),
	.out_image_wr(out_image_wr), .out_image_data(out_image_data), .rec_rd(rec_rd), .rec_num(rec_num),
	.rec_idx(rec_idx), .input_image_byte(input_image_byte), .output_image_byte(output_image_byte),
	.rec_valid(rec_valid), .rec_refused(rec_refused), .rec_data(rec_data), .diag_irq_incoming(diag_irq_incoming),
	.diag_irq_going(diag_irq_going), .led_status_green(led_status_green), .led_status_red(led_status_red),
	.led_out(led_out));
`default_nettype wire

// *** tb/head_station_model.sv ***
// Purpose: Head station writing the output image and reading the record
// Assumes: Strobes last one clk_sys cycle
// Notes:   Qualifiers are inverted once a strobe is released
`timescale 1ns/1ns
`default_nettype none
module head_station_model (
	// Clock
	input wire logic       clk_sys,
	// Image write
	output var logic       out_image_wr,
	output var logic [7:0] out_image_data,
	// Record read
	output var logic       rec_rd,
	output var logic [7:0] rec_num,
	output var logic [4:0] rec_idx,
	input wire logic       rec_valid,
	input wire logic       rec_refused,
	input wire logic [7:0] rec_data
);
	// Idle levels at time zero
	initial begin
		out_image_wr = 1'b0;
		out_image_data = 8'h00;
		rec_rd = 1'b0;
		rec_num = 8'h00;
		rec_idx = 5'h00;
	end
	// One output image byte, bit n for output n
	task automatic write_image(input logic [7:0] d);
		@(posedge clk_sys);
		out_image_wr <= 1'b1;
		out_image_data <= d;
		@(posedge clk_sys);
		out_image_wr <= 1'b0;
		out_image_data <= ~d;
	endtask
	// One record byte, taken at the edge that shows the answer
	task automatic read_rec(input logic [7:0] num, input logic [4:0] idx, output logic [7:0] d, output logic rf);
		d = 8'hXX;
		rf = 1'bx;
		@(posedge clk_sys);
		rec_rd <= 1'b1;
		rec_num <= num;
		rec_idx <= idx;
		@(posedge clk_sys);
		rec_rd <= 1'b0;
		rec_num <= ~num;
		rec_idx <= ~idx;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			if (rec_valid === 1'b1) begin
				d = rec_data;
				rf = rec_refused;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// *** tb/mixed_digital_io_diag_test.sv ***
// Purpose: Self-checking bench for the mixed digital I/O unit
// Assumes: 20 MHz clk_sys, blink half period cut to 8 cycles
// Notes:   Expected values come from the record layout and light rules
`timescale 1ns/1ns
`default_nettype none
module mixed_digital_io_diag_test;
	localparam int B = 8;
	logic        clk_sys, rst_n, wr, rd, vld, rfd, irq_en, inc, gon, grn, red, bce, rf, prev;
	logic [4:0]  cond, idx;
	logic [7:0]  fin, fout, ovl, iib, wdat, oib, num, rdat, lin, lout, d, x;
	logic [31:0] ts;
	int          n_errors, checks_done, cyc, n_in, n_go, t0, tog;
	logic [7:0]  rec_q [$] = '{8'h00, 8'h0F, 8'h00, 8'h00, 8'h72, 8'h00, 8'h00, 8'h00};
	int          flag_bit [0:4] = '{0, 1, 2, 4, 7};

	mixed_digital_io_diag #(.BLINK_HALF_CYCLES(B), .CH(8)) u_mixed_digital_io_diag (
		.clk_sys(clk_sys), .rst_n(rst_n), .field_in(fin), .field_out(fout), .out_overload(ovl),
		.diag_irq_enable(irq_en), .module_failure(cond[0]), .internal_error(cond[1]),
		.external_error(cond[2]), .param_error(cond[4]), .bus_comm_error(bce), .input_image_byte(iib),
		.out_image_wr(wr), .out_image_data(wdat), .output_image_byte(oib), .rec_rd(rd), .rec_num(num),
		.rec_idx(idx), .rec_valid(vld), .rec_refused(rfd), .rec_data(rdat), .diag_irq_incoming(inc),
		.diag_irq_going(gon), .led_status_green(grn), .led_status_red(red), .led_in(lin), .led_out(lout));
	head_station_model u_head_station_model (
		.clk_sys(clk_sys), .out_image_wr(wr), .out_image_data(wdat), .rec_rd(rd), .rec_num(num),
		.rec_idx(idx), .rec_valid(vld), .rec_refused(rfd), .rec_data(rdat));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Cycle count, interrupt pulse counts and hang limit
	always @(posedge clk_sys) begin
		cyc++;
		if (inc === 1'b1) n_in++;
		if (gon === 1'b1) n_go++;
		if (cyc == 3000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
		checks_done++;
		if ($isunknown(g) || g < lo || g > hi) begin
			n_errors++;
			$display("unexpected %s expected %0d to %0d seen %h", nm, lo, hi, g);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		fin = 8'h00;
		ovl = 8'h00;
		cond = 5'h00;
		irq_en = 1'b0;
		bce = 1'b0;
		void'($urandom(32'h81a991fc));
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t0 = cyc;
		repeat (24) @(posedge clk_sys);
		// Fixed record bytes, then refused reads
		for (int i = 0; i < 16; i++) begin
			u_head_station_model.read_rec(8'h01, i[4:0], d, rf);
			chk("record byte", (i < 8) ? rec_q[i] : 8'h00, d);
			chk("record refused", 0, rf);
		end
		for (int k = 0; k < 2; k++) begin
			u_head_station_model.read_rec(k ? 8'h01 : 8'h02, k ? 5'h14 : 5'h04, d, rf);
			chk("refused data", 8'h00, d);
			chk("refused flag", 1, rf);
		end
		// Process images and channel lights
		for (int i = 0; i < 16; i++) begin
			x = (i == 0) ? 8'hFF : 8'($urandom);
			d = (i == 1) ? 8'hFF : 8'($urandom);
			@(posedge clk_sys);
			fin <= x;
			u_head_station_model.write_image(d);
			repeat (2) @(posedge clk_sys);
			chk("input image", x, iib);
			chk("input lights", x, lin);
			chk("output image", d, oib);
			chk("output drive", d, fout);
			chk("output lights", d, lout);
		end
		// Each error condition in the flag byte with its time stamp
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_sys);
			cond[k] <= 1'b1;
			if (k == 3) ovl <= 8'h01 << ($urandom % 8);
			tog = (cyc - t0) / 20;
			repeat (24) @(posedge clk_sys);
			u_head_station_model.read_rec(8'h01, 5'h00, d, rf);
			chk("flag byte", 8'h01 << flag_bit[k], d);
			for (int j = 0; j < 4; j++) begin
				u_head_station_model.read_rec(8'h01, 5'(16 + j), d, rf);
				ts[8*j +: 8] = d;
			end
			chk_rng("time stamp", tog - 1, tog + 1, ts);
			@(posedge clk_sys);
			cond <= 5'h00;
			ovl <= 8'h00;
			repeat (24) @(posedge clk_sys);
		end
		// Overload with the interrupt parameter set at the rise, changed at the fall
		for (int en = 0; en < 4; en++) begin
			@(posedge clk_sys);
			irq_en <= en[0];
			ovl <= 8'h80 | 8'($urandom);
			tog = n_in;
			repeat (6) @(posedge clk_sys);
			chk("incoming count", en[0], n_in - tog);
			chk("red light", 1, red);
			tog = n_go;
			irq_en <= en[1];
			ovl <= 8'h00;
			repeat (6) @(posedge clk_sys);
			chk("going count", en[0], n_go - tog);
			chk("red light", 0, red);
			chk("green light", 1, grn);
		end
		// Status lights flash under configuration and bus errors
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			cond[4] <= (k == 0);
			bce <= k[0];
			repeat (2) @(posedge clk_sys);
			tog = 0;
			prev = k ? grn : red;
			repeat (4 * B) begin
				@(posedge clk_sys);
				tog += ((k ? grn : red) !== prev);
				prev = k ? grn : red;
			end
			chk_rng("light toggles", 3, 5, tog);
		end
		close_out();
	end
endmodule
`default_nettype wire
